// file: shared/pfri_pkg.sv
`default_nettype none
package pfri_pkg;
    // ***************************************
    // Register map and fields
    // ***************************************
    localparam logic [1:0] ADDR_CTRL     = 2'h0;  // Run bit and running mode
    localparam logic [1:0] ADDR_CFG_A    = 2'h1;  // Input A configuration
    localparam logic [1:0] ADDR_CFG_B    = 2'h2;  // Input B configuration
    localparam logic [1:0] ADDR_STATUS   = 2'h3;  // Read-only state
    localparam int         CTRL_RUN_BIT  = 0;     // controller_run_bit
    localparam int         CTRL_RAMP_LSB = 1;     // Running mode, two bits
    localparam int         CFG_MODE_LSB  = 0;     // input_mode_select, four bits
    localparam int         CFG_POL_BIT   = 4;     // input_active_polarity
    localparam int         CFG_FILT_BIT  = 5;     // Filter enable
    localparam int         CFG_AKILL_BIT = 6;     // async_output_kill_enable
    localparam logic [7:0] CTRL_RST      = 8'h00; // Stopped, one ramp
    localparam logic [7:0] CFG_RST       = 8'h00; // Mode 0, low active
    // ***************************************
    // Running modes and ramp phases
    // ***************************************
    localparam logic [1:0] RAMP_ONE    = 2'h0;
    localparam logic [1:0] RAMP_TWO    = 2'h1;
    localparam logic [1:0] RAMP_FOUR   = 2'h2;
    localparam logic [1:0] RAMP_CENTER = 2'h3;
    localparam logic [1:0] PH_DT0      = 2'h0;  // dead_time_0
    localparam logic [1:0] PH_OT0      = 2'h1;  // on_time_0
    localparam logic [1:0] PH_DT1      = 2'h2;  // dead_time_1
    localparam logic [1:0] PH_OT1      = 2'h3;  // on_time_1
    // ***************************************
    // Input modes
    // ***************************************
    localparam logic [3:0] MODE_NONE = 4'h0;
    localparam logic [3:0] MODE_1    = 4'h1;
    localparam logic [3:0] MODE_2    = 4'h2;
    localparam logic [3:0] MODE_3    = 4'h3;
    localparam logic [3:0] MODE_4    = 4'h4;
    localparam logic [3:0] MODE_5    = 4'h5;
    localparam logic [3:0] MODE_6    = 4'h6;
    localparam logic [3:0] MODE_7    = 4'h7;
    localparam logic [3:0] MODE_8    = 4'h8;
    localparam logic [3:0] MODE_9    = 4'h9;
    localparam logic [3:0] MODE_14   = 4'he;
    localparam logic [3:0] FILT_ONES = 4'hf;  // Four samples all high
    localparam logic [3:0] FILT_ZERO = 4'h0;  // Four samples all low
    // Channel sequencer states
    typedef enum logic [2:0] {
        ST_IDLE     = 3'h0,  // Watching the input
        ST_WAIT_REL = 3'h1,  // Output off, counter held until release
        ST_OPP_RUN  = 3'h2,  // Opposite sub-cycle running
        ST_WAIT_AFT = 3'h3,  // Held after jump until release
        ST_REPEAT   = 3'h4,  // Opposite pulse repeats while active
        ST_EDGE_OFF = 3'h5   // Output off until next ramp
    } pfri_state_t;
endpackage : pfri_pkg
`default_nettype wire

// file: src/pfri_top.sv
`timescale 1ns/100ps
`default_nettype none
// ***************************************
// One input channel: sync, filter, sequencer
// ***************************************
module pfri_channel #(
    parameter logic IS_B = 1'b0              // Input B owns half 1
) (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       pin,             // Pin or comparator level
    input  wire logic [7:0] cfg,             // Channel configuration
    input  wire logic [1:0] ramp,            // Running mode
    input  wire logic [1:0] phase,           // Current ramp phase
    input  wire logic       run,             // Controller running
    output var  logic       act,             // Active after polarity
    output var  logic       kill_own,        // Own output off
    output var  logic       kill_all,        // Both outputs off
    output var  logic       jump_opp,        // Jump to opposite dead-time
    output var  logic       jump_cur,        // Jump opposite current half
    output var  logic       end_pulse,       // End pulse, insert dead-time
    output var  logic       restart,         // Restart ramp
    output var  logic       hold,            // Freeze counter
    output var  logic       halt,            // Stop controller
    output var  logic       busy             // Sequencer not idle
);
    // Whole channel state
    typedef struct packed {
        logic                s1;       // First sync stage
        logic                s2;       // Second sync stage
        logic [3:0]          hist;     // Last four samples
        logic                filt;     // Filtered level
        logic                act_prev; // For edge detection
        logic                seen;     // Left own half since jump
        pfri_pkg::pfri_state_t st;
    } pfri_ch_t;

    pfri_ch_t q;                 // Registered state
    pfri_ch_t d;                 // Next state
    logic [3:0] mode;            // Decoded mode field
    logic       level;           // Level after optional filter
    logic       edge_evt;        // Active edge
    logic       in_own;          // Phase in own half
    logic       on_own;          // Phase in own on-time
    logic       win;             // Input may act
    logic       retrig_ok;       // Retrigger allowed in this mode
    logic [1:0] own_dt;          // Own dead-time code
    logic [1:0] own_ot;          // Own on-time code

    assign mode   = cfg[pfri_pkg::CFG_MODE_LSB +: 4];
    assign own_dt = IS_B ? pfri_pkg::PH_DT1 : pfri_pkg::PH_DT0;
    assign own_ot = IS_B ? pfri_pkg::PH_OT1 : pfri_pkg::PH_OT0;
    assign in_own = (phase == own_dt) || (phase == own_ot);
    assign on_own = (phase == own_ot);

    // Filter bypass keeps latency low on slow clocks
    // filter select
    assign level    = cfg[pfri_pkg::CFG_FILT_BIT] ? q.filt : q.s2;
    assign act      = cfg[pfri_pkg::CFG_POL_BIT] ? level : ~level;
    assign edge_evt = act & ~q.act_prev;
    // own half only in two/four/centered ramp
    assign win       = (ramp == pfri_pkg::RAMP_ONE) || in_own;
    assign retrig_ok = (ramp != pfri_pkg::RAMP_CENTER);
    assign busy      = (q.st != pfri_pkg::ST_IDLE);
    assign hold      = (q.st == pfri_pkg::ST_WAIT_REL) || (q.st == pfri_pkg::ST_WAIT_AFT);
    // mode 4 gates both outputs, either half
    assign kill_all  = run && (mode == pfri_pkg::MODE_4) && act;
    // mode 14 holds own output off while active, except in centered ramp
    // mode 9 off state gates own output only
    assign kill_own  = busy || (run && retrig_ok && (mode == pfri_pkg::MODE_14) && act);

    // Next-state and event pulses
    always_comb
    begin
        d         = q;
        jump_opp  = 1'b0;
        jump_cur  = 1'b0;
        end_pulse = 1'b0;
        restart   = 1'b0;
        halt      = 1'b0;
        d.s1       = pin;
        d.s2       = q.s1;
        // four equal samples flip the filter
        d.hist     = {q.hist[2:0], q.s2};
        if (q.hist == pfri_pkg::FILT_ONES)
        begin
            d.filt = 1'b1;
        end
        else if (q.hist == pfri_pkg::FILT_ZERO)
        begin
            d.filt = 1'b0;
        end
        d.act_prev = act;
        // Track leaving own half after a jump
        if (!in_own)
        begin
            d.seen = 1'b1;
        end
        case (q.st)
            pfri_pkg::ST_IDLE:
            begin
                d.seen = 1'b0;
                // mode decode, reserved codes do nothing
                if (run)
                begin
                    case (mode)
                        pfri_pkg::MODE_1:
                        begin
                            if (win && act)
                            begin
                                d.st = pfri_pkg::ST_WAIT_REL;
                            end
                        end
                        pfri_pkg::MODE_2:
                        begin
                            if (win && act)
                            begin
                                jump_opp = 1'b1;
                                d.st     = pfri_pkg::ST_OPP_RUN;
                            end
                        end
                        pfri_pkg::MODE_3:
                        begin
                            if (win && act)
                            begin
                                jump_opp = 1'b1;
                                d.st     = pfri_pkg::ST_REPEAT;
                            end
                        end
                        pfri_pkg::MODE_5:
                        begin
                            end_pulse = edge_evt;
                        end
                        pfri_pkg::MODE_6:
                        begin
                            // jump from current half, then wait
                            if (edge_evt)
                            begin
                                jump_cur = 1'b1;
                                d.st     = pfri_pkg::ST_WAIT_AFT;
                            end
                        end
                        pfri_pkg::MODE_7:
                        begin
                            halt = act;
                        end
                        pfri_pkg::MODE_8:
                        begin
                            if (retrig_ok && edge_evt && on_own)
                            begin
                                restart  = (ramp == pfri_pkg::RAMP_ONE);
                                jump_opp = (ramp != pfri_pkg::RAMP_ONE);
                            end
                        end
                        pfri_pkg::MODE_9:
                        begin
                            if (retrig_ok && edge_evt && on_own)
                            begin
                                d.st = pfri_pkg::ST_EDGE_OFF;
                            end
                        end
                        default:
                        begin
                            d.st = pfri_pkg::ST_IDLE;
                        end
                    endcase
                end
            end
            pfri_pkg::ST_WAIT_REL:
            begin
                if (!act)
                begin
                    jump_opp = 1'b1;
                    d.st     = pfri_pkg::ST_IDLE;
                end
            end
            pfri_pkg::ST_OPP_RUN:
            begin
                // release ignored until back in own half
                if (q.seen && in_own)
                begin
                    d.st = act ? pfri_pkg::ST_WAIT_AFT : pfri_pkg::ST_IDLE;
                end
            end
            pfri_pkg::ST_WAIT_AFT:
            begin
                if (!act)
                begin
                    d.st = pfri_pkg::ST_IDLE;
                end
            end
            pfri_pkg::ST_REPEAT:
            begin
                // opposite pulse plus own dead-time complete
                if (q.seen && on_own)
                begin
                    d.seen   = 1'b0;
                    jump_opp = act;
                    d.st     = act ? pfri_pkg::ST_REPEAT : pfri_pkg::ST_IDLE;
                end
            end
            pfri_pkg::ST_EDGE_OFF:
            begin
                // output back on at next ramp
                if (!on_own)
                begin
                    d.st = pfri_pkg::ST_IDLE;
                end
            end
            default:
            begin
                d.st = pfri_pkg::ST_IDLE;
            end
        endcase
        // Stopped controller drops any sequence
        if (!run)
        begin
            d.st = pfri_pkg::ST_IDLE;
        end
    end

    // State register
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    // ***************************************
    // Channel checks
    // ***************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    chk_filter_span: assert property ($rose(q.filt) |->
        $past(q.s2, 2) && $past(q.s2, 3) && $past(q.s2, 4) && $past(q.s2, 5))
        else $error("filter rose without four high samples");
    chk_half_window: assert property (
        (q.st == pfri_pkg::ST_IDLE && mode == pfri_pkg::MODE_1 && ramp == pfri_pkg::RAMP_TWO
         && !in_own) |=> q.st == pfri_pkg::ST_IDLE)
        else $error("mode 1 acted outside its own half");
    chk_m1_release: assert property ((q.st == pfri_pkg::ST_WAIT_REL && !act && run)
        |-> jump_opp ##1 q.st == pfri_pkg::ST_IDLE)
        else $error("mode 1 release did not jump");
    chk_m9_edge: assert property ((run && retrig_ok && mode == pfri_pkg::MODE_9 &&
        q.st == pfri_pkg::ST_IDLE && edge_evt) |=> (q.st == pfri_pkg::ST_EDGE_OFF) == $past(on_own))
        else $error("mode 9 edge window wrong");
    chk_center_ign: assert property ((ramp == pfri_pkg::RAMP_CENTER) |-> !restart)
        else $error("retrigger acted in centered mode");
    cov_mode3_loop: cover property (q.st == pfri_pkg::ST_REPEAT && jump_opp);
    cov_mode2_wait: cover property (q.st == pfri_pkg::ST_OPP_RUN ##1 q.st == pfri_pkg::ST_WAIT_AFT);
endmodule : pfri_channel

// ***************************************
// Input stage top with register port
// ***************************************
module pfri_top (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       in_a,            // fault_input_pins, input A
    input  wire logic       in_b,            // fault_input_pins, input B
    input  wire logic [1:0] phase,           // Ramp phase from counter core
    input  wire logic [1:0] addr,            // Register address
    input  wire logic [7:0] wdata,           // Write data
    input  wire logic       wr,              // Write strobe
    input  wire logic       rd,              // Read strobe
    output var  logic [7:0] rdata,           // Read data, one cycle later
    output var  logic       async_kill,      // Clockless output kill
    output var  logic       out0_off,        // Force wave_output_0 inactive
    output var  logic       out1_off,        // Force wave_output_1 inactive
    output var  logic       jump_dt0,        // Jump to dead_time_0
    output var  logic       jump_dt1,        // Jump to dead_time_1
    output var  logic       insert_dt,       // End pulse, insert dead-time
    output var  logic       restart_ramp,    // Restart ramp from zero
    output var  logic       hold_count,      // Freeze counter
    output var  logic       run              // controller_run_bit
);
    // Whole top state
    typedef struct packed {
        logic [7:0] ctrl;    // controller_control_register
        logic [7:0] cfg_a;   // Input A configuration
        logic [7:0] cfg_b;   // Input B configuration
        logic [7:0] rdata;   // Read return
        logic       off0;
        logic       off1;
        logic       jdt0;
        logic       jdt1;
        logic       ins;
        logic       rst_r;
        logic       hold;
    } pfri_top_t;

    pfri_top_t q;        // Registered state
    pfri_top_t d;        // Next state
    logic [1:0] ramp;    // Running mode
    logic       run_i;   // Run bit
    logic       half0;   // Phase in half 0
    logic       a_act, a_ko, a_ka, a_jo, a_jc, a_ep, a_rs, a_hd, a_ht, a_bz;
    logic       b_act, b_ko, b_ka, b_jo, b_jc, b_ep, b_rs, b_hd, b_ht, b_bz;

    assign ramp  = q.ctrl[pfri_pkg::CTRL_RAMP_LSB +: 2];
    assign run_i = q.ctrl[pfri_pkg::CTRL_RUN_BIT];
    assign half0 = (phase == pfri_pkg::PH_DT0) || (phase == pfri_pkg::PH_OT0);

    // channels keep processing the inputs with the clock
    pfri_channel #(.IS_B(1'b0)) u_ch_a (
        .ref_clk(ref_clk), .rst(rst), .pin(in_a), .cfg(q.cfg_a), .ramp(ramp),
        .phase(phase), .run(run_i), .act(a_act), .kill_own(a_ko), .kill_all(a_ka),
        .jump_opp(a_jo), .jump_cur(a_jc), .end_pulse(a_ep), .restart(a_rs),
        .hold(a_hd), .halt(a_ht), .busy(a_bz)
    );
    pfri_channel #(.IS_B(1'b1)) u_ch_b (
        .ref_clk(ref_clk), .rst(rst), .pin(in_b), .cfg(q.cfg_b), .ramp(ramp),
        .phase(phase), .run(run_i), .act(b_act), .kill_own(b_ko), .kill_all(b_ka),
        .jump_opp(b_jo), .jump_cur(b_jc), .end_pulse(b_ep), .restart(b_rs),
        .hold(b_hd), .halt(b_ht), .busy(b_bz)
    );

    // unclocked kill path, stays alive when the clock stops
    assign async_kill =
        (q.cfg_a[pfri_pkg::CFG_AKILL_BIT] && (in_a == q.cfg_a[pfri_pkg::CFG_POL_BIT])) ||
        (q.cfg_b[pfri_pkg::CFG_AKILL_BIT] && (in_b == q.cfg_b[pfri_pkg::CFG_POL_BIT]));

    // Register port and command staging
    always_comb
    begin
        d = q;
        // Software writes
        if (wr)
        begin
            case (addr)
                pfri_pkg::ADDR_CTRL:  d.ctrl  = wdata;
                pfri_pkg::ADDR_CFG_A: d.cfg_a = wdata;
                pfri_pkg::ADDR_CFG_B: d.cfg_b = wdata;
                default:              d.ctrl  = q.ctrl;  // Status is read-only
            endcase
        end
        // halt clears run; wins over a same-cycle write
        if (a_ht || b_ht)
        begin
            d.ctrl[pfri_pkg::CTRL_RUN_BIT] = 1'b0;
        end
        // Read data valid only the cycle after the strobe
        d.rdata = 8'h00;
        if (rd)
        begin
            case (addr)
                pfri_pkg::ADDR_CTRL:   d.rdata = q.ctrl;
                pfri_pkg::ADDR_CFG_A:  d.rdata = q.cfg_a;
                pfri_pkg::ADDR_CFG_B:  d.rdata = q.cfg_b;
                pfri_pkg::ADDR_STATUS: d.rdata = {3'h0, b_bz, a_bz, b_act, a_act, run_i};
                default:               d.rdata = 8'h00;
            endcase
        end
        d.off0 = a_ko || a_ka || b_ka;
        d.off1 = b_ko || a_ka || b_ka;
        // A jumps into half 1, B into half 0
        // mode 6 jumps away from the current half
        d.jdt1 = a_jo || ((a_jc || b_jc) && half0);
        d.jdt0 = b_jo || ((a_jc || b_jc) && !half0);
        d.ins   = a_ep || b_ep;
        d.rst_r = a_rs || b_rs;
        d.hold  = a_hd || b_hd;
    end

    // State register
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            q       <= '0;
            q.ctrl  <= pfri_pkg::CTRL_RST;
            q.cfg_a <= pfri_pkg::CFG_RST;
            q.cfg_b <= pfri_pkg::CFG_RST;
        end
        else
        begin
            q <= d;
        end
    end

    assign rdata        = q.rdata;
    assign out0_off     = q.off0;
    assign out1_off     = q.off1;
    assign jump_dt0     = q.jdt0;
    assign jump_dt1     = q.jdt1;
    assign insert_dt    = q.ins;
    assign restart_ramp = q.rst_r;
    assign hold_count   = q.hold;
    assign run          = run_i;

    // ***************************************
    // Top checks
    // ***************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    chk_halt_run: assert property ((a_ht || b_ht) |=> !run)
        else $error("halt did not clear run");
    chk_async_kill: assert property ((q.cfg_a[pfri_pkg::CFG_AKILL_BIT] &&
        in_a == q.cfg_a[pfri_pkg::CFG_POL_BIT]) |-> async_kill)
        else $error("async kill missing for input A");
    chk_mode4_both: assert property ((a_ka || b_ka) |=> out0_off && out1_off)
        else $error("mode 4 left an output on");
    chk_jump_route: assert property ($rose(a_jo) |=> jump_dt1 ##1 !jump_dt1 || $past(a_jo))
        else $error("input A jump not routed to dead_time_1");
    chk_read_ctrl: assert property ((rd && addr == pfri_pkg::ADDR_CTRL && !wr) |=>
        rdata == $past(q.ctrl))
        else $error("control read data wrong");
    cov_halt: cover property (run ##1 (a_ht || b_ht) ##1 !run);
    cov_kill: cover property (async_kill && out0_off);
endmodule : pfri_top
`default_nettype wire

// file: bench/pfri_fault_src.sv
`timescale 1ns/100ps
`default_nettype none
// ********
// Fault pin model
// ********
module pfri_fault_src (
    input  wire logic ref_clk,
    input  wire logic lvl,         // Wanted level
    input  wire logic slow,        // Two extra cycles of lag
    output var  logic pin          // Pin into block
);
    logic [1:0] dly_q;             // Lag line
    // Slow comparator settles late
    always_ff @(posedge ref_clk)
    begin
        dly_q <= {dly_q[0], lvl};
        pin   <= slow ? dly_q[1] : lvl;
    end
endmodule : pfri_fault_src
`default_nettype wire

// file: bench/pfri_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module pfri_top_tb;
    logic ref_clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, lvl_a = 1'b0, lvl_b = 1'b0, slow = 1'b0;
    logic [1:0] phase = 2'h0, addr = 2'h0;
    logic [7:0] wdata = 8'h00, rdata, v;
    logic in_a, in_b, async_kill, out0_off, out1_off, jump_dt0, jump_dt1, insert_dt, restart_ramp, hold_count, run;
    logic [8:0] obs;   // Watched outputs by index
    int fail_count = 0, comparisons = 0, exp_ctrl, seed;
    logic [3:0] modes [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'he};
    assign obs = {insert_dt, jump_dt0, restart_ramp, jump_dt1, hold_count, run, out1_off, out0_off, async_kill};
    pfri_fault_src i_src_a (.ref_clk(ref_clk), .lvl(lvl_a), .slow(slow), .pin(in_a));
    pfri_fault_src i_src_b (.ref_clk(ref_clk), .lvl(lvl_b), .slow(slow), .pin(in_b));
    pfri_top i_dut (.ref_clk(ref_clk), .rst(rst), .in_a(in_a), .in_b(in_b), .phase(phase), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .async_kill(async_kill), .out0_off(out0_off),
        .out1_off(out1_off), .jump_dt0(jump_dt0), .jump_dt1(jump_dt1), .insert_dt(insert_dt),
        .restart_ramp(restart_ramp), .hold_count(hold_count), .run(run));
    initial forever #2.5 ref_clk = ~ref_clk;
    task automatic results();
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : results
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Bounded wait on one output
    task automatic wait_for(input int i, input logic e);
        int n;
        n = 0;
        #1;
        while (obs[i] !== e && n < 20)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        chk({7'h0, obs[i]}, {7'h0, e});
        if (obs[i] !== e)
            results();
    endtask : wait_for
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : idle
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge ref_clk);
        wr    <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [1:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge ref_clk);
        rd   <= 1'b0;
        #1;
        chk(rdata, e);
    endtask : rd_chk
    initial
    begin
        seed = $urandom(49);
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        rd_chk(pfri_pkg::ADDR_CTRL, pfri_pkg::CTRL_RST);
        rd_chk(pfri_pkg::ADDR_STATUS, 8'h06);
        foreach (modes[i])
        begin
            v = {3'h0, 1'($urandom), modes[i]};
            wr_reg(pfri_pkg::ADDR_CFG_B, v);
            rd_chk(pfri_pkg::ADDR_CFG_B, v);
        end
        wr_reg(pfri_pkg::ADDR_CFG_B, 8'h00);
        for (int p = 0; p < 2; p++)
        begin
            wr_reg(pfri_pkg::ADDR_CFG_A, 8'h40 | 8'(p << 4));
            lvl_a <= p[0];
            wait_for(0, 1'b1);
            lvl_a <= ~p[0];
            wait_for(0, 1'b0);
        end
        exp_ctrl = 8'h03;
        wr_reg(pfri_pkg::ADDR_CTRL, 8'(exp_ctrl));
        wr_reg(pfri_pkg::ADDR_CFG_A, 8'h11);
        phase <= pfri_pkg::PH_DT1;
        lvl_a <= 1'b1;
        idle(8);
        chk({7'h0, out0_off}, 8'h00);
        lvl_a <= 1'b0;
        idle(4);
        @(posedge ref_clk);
        phase <= pfri_pkg::PH_OT0;
        slow  <= 1'b1;
        lvl_a <= 1'b1;
        wait_for(1, 1'b1);
        wait_for(4, 1'b1);
        lvl_a <= 1'b0;
        wait_for(5, 1'b1);
        wait_for(4, 1'b0);
        slow <= 1'b0;
        wr_reg(pfri_pkg::ADDR_CFG_B, 8'h34);
        lvl_b <= 1'b1;
        idle(5);
        chk({7'h0, out1_off}, 8'h00);
        wait_for(2, 1'b1);
        chk({7'h0, out0_off}, 8'h01);
        lvl_b <= 1'b0;
        wait_for(2, 1'b0);
        wr_reg(pfri_pkg::ADDR_CFG_A, 8'h17);
        lvl_a <= 1'b1;
        wait_for(3, 1'b0);
        exp_ctrl = exp_ctrl & 8'hfe;
        rd_chk(pfri_pkg::ADDR_CTRL, 8'(exp_ctrl));
        lvl_a <= 1'b0;
        idle(6);
        exp_ctrl = 8'h01;
        wr_reg(pfri_pkg::ADDR_CTRL, 8'(exp_ctrl));
        rd_chk(pfri_pkg::ADDR_CTRL, 8'(exp_ctrl));
        wr_reg(pfri_pkg::ADDR_CFG_A, 8'h18);
        lvl_a <= 1'b1;
        wait_for(6, 1'b1);
        // Input B retrigger, two ramp then centered
        wr_reg(pfri_pkg::ADDR_CTRL, 8'h03);
        wr_reg(pfri_pkg::ADDR_CFG_B, 8'h18);
        phase <= pfri_pkg::PH_OT1;
        lvl_b <= 1'b1;
        wait_for(7, 1'b1);
        lvl_b <= 1'b0;
        wr_reg(pfri_pkg::ADDR_CFG_B, 8'h19);
        phase <= pfri_pkg::PH_OT0;
        lvl_b <= 1'b1;
        idle(8);
        chk({7'h0, out1_off}, 8'h00);
        lvl_b <= 1'b0;
        idle(4);
        @(posedge ref_clk);
        phase <= pfri_pkg::PH_OT1;
        lvl_b <= 1'b1;
        wait_for(2, 1'b1);
        chk({7'h0, out0_off}, 8'h00);
        @(posedge ref_clk);
        phase <= pfri_pkg::PH_DT0;
        wait_for(2, 1'b0);
        @(posedge ref_clk);
        phase <= pfri_pkg::PH_OT1;
        idle(6);
        chk({7'h0, out1_off}, 8'h00);
        wr_reg(pfri_pkg::ADDR_CFG_B, 8'h1e);
        wait_for(2, 1'b1);
        wr_reg(pfri_pkg::ADDR_CTRL, 8'h07);
        wait_for(2, 1'b0);
        // Input A edge and level modes
        wr_reg(pfri_pkg::ADDR_CTRL, 8'h03);
        wr_reg(pfri_pkg::ADDR_CFG_A, 8'h15);
        lvl_a <= 1'b0;
        lvl_b <= 1'b0;
        idle(4);
        lvl_a <= 1'b1;
        wait_for(8, 1'b1);
        lvl_a <= 1'b0;
        wr_reg(pfri_pkg::ADDR_CFG_A, 8'h12);
        idle(4);
        @(posedge ref_clk);
        phase <= pfri_pkg::PH_OT0;
        lvl_a <= 1'b1;
        wait_for(5, 1'b1);
        lvl_a <= 1'b0;
        @(posedge ref_clk);
        phase <= pfri_pkg::PH_DT1;
        idle(6);
        chk({7'h0, out0_off}, 8'h01);
        @(posedge ref_clk);
        phase <= pfri_pkg::PH_DT0;
        wait_for(1, 1'b0);
        wr_reg(pfri_pkg::ADDR_CFG_A, 8'h13);
        lvl_a <= 1'b1;
        wait_for(5, 1'b1);
        @(posedge ref_clk);
        phase <= pfri_pkg::PH_DT1;
        idle(2);
        @(posedge ref_clk);
        phase <= pfri_pkg::PH_OT0;
        wait_for(5, 1'b1);
        lvl_a <= 1'b0;
        @(posedge ref_clk);
        phase <= pfri_pkg::PH_DT1;
        idle(4);
        @(posedge ref_clk);
        phase <= pfri_pkg::PH_OT0;
        wait_for(1, 1'b0);
        wr_reg(pfri_pkg::ADDR_CFG_A, 8'h16);
        lvl_a <= 1'b1;
        wait_for(5, 1'b1);
        wait_for(4, 1'b1);
        lvl_a <= 1'b0;
        wait_for(4, 1'b0);
        results();
    end
endmodule : pfri_top_tb
`default_nettype wire
